// >>> buzzer_timer_pkg.sv
// Purpose: Shared constants for the free-running timer with buzzer output.
// Assumes: SYS_CLK is the main clock; the subsystem clock is sampled from a pin.
// Notes: Prescale masks give the count-clock period as a power of two.
package buzzer_timer_pkg;
    // Count-clock select codes
    localparam logic [1:0] CLK_SEL_DIV4 = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV64 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV128 = 2'h2;
    localparam logic [1:0] CLK_SEL_SUB = 2'h3;
    // Prescaler masks for main clock divided by 4, 64 and 128
    localparam int PRE_W = 7;
    localparam logic [6:0] PRE_MASK_DIV4 = 7'h03;
    localparam logic [6:0] PRE_MASK_DIV64 = 7'h3F;
    localparam logic [6:0] PRE_MASK_DIV128 = 7'h7F;
    localparam logic [6:0] PRE_RESET = 7'h00;
    // Buzzer divider width covers the largest ratio of 8192
    localparam int BZ_DIV_W = 13;
    localparam logic [12:0] BZ_DIV_RESET = 13'h0000;
    // Counter, compare and capture reset values
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
endpackage : buzzer_timer_pkg

// >>> buzzer_src_if.sv
// Purpose: Carries the buzzer source clock tick and settings to the divider.
// Assumes: All signals are on SYS_CLK.
// Notes: The timer drives the tick; the divider returns the square wave.
interface buzzer_src_if;
    logic src_tick;
    logic [2:0] div_sel;
    logic wave;
    modport timer (output src_tick, output div_sel, input wave);
    modport divider (input src_tick, input div_sel, output wave);
endinterface : buzzer_src_if

// >>> buzzer_divider.sv
// Purpose: Divides the timer count clock into the buzzer square wave.
// Assumes: src_tick is a one-cycle pulse once per count-clock period.
// Notes: A select change takes effect at the next source tick.
module buzzer_divider (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Source tick, select and wave
    buzzer_src_if.divider bz
);
    logic [12:0] div;
    logic [12:0] next_div;
    logic [3:0] tap;

    // Bit of the divider whose period is the selected ratio
    function automatic logic [3:0] tap_of(input logic [2:0] sel);
        logic [3:0] t;
        t = 4'h3;
        unique case (sel)
            3'h0: t = 4'h3;
            3'h1: t = 4'h4;
            3'h2: t = 4'h7;
            3'h3: t = 4'h8;
            3'h4: t = 4'h9;
            3'h5: t = 4'hA;
            3'h6: t = 4'hB;
            3'h7: t = 4'hC;
        endcase
        return t;
    endfunction : tap_of

    // Divider step and tap selection
    assign next_div = div + 13'h0001;
    assign tap = tap_of(bz.div_sel);

    // Free-running divider; the tapped bit gives 50 percent duty
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            div <= buzzer_timer_pkg::BZ_DIV_RESET;
            bz.wave <= 1'b0;
        end else if (bz.src_tick) begin
            div <= next_div;
            bz.wave <= next_div[tap];
        end
    end

    wave_on_tick_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        $changed(bz.wave) |-> $past(bz.src_tick))
        else $error("Buzzer wave changed without a source tick");
    div16_period_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (bz.src_tick && bz.div_sel == 3'h0 && div[2:0] == 3'h7) |=> bz.wave == div[3])
        else $error("Divide-by-16 wave does not follow divider bit 3");
endmodule : buzzer_divider

// >>> buzzer_timer.sv
// Purpose: 16-bit free-running timer with compare, capture, readout and buzzer.
// Assumes: SYS_CLK is the main clock; SUB_CLK is the subsystem clock pin.
// Notes: Control bits are plain ports driven by CPU-side logic on SYS_CLK.
module buzzer_timer (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Clock status
    input wire logic SUB_CLK,
    input wire logic MAIN_CLK_RUN,
    input wire logic CPU_ON_SUB,
    input wire logic CPU_HIGH_SPEED,
    // Mode control
    input wire logic [1:0] COUNT_CLK_SEL,
    input wire logic [2:0] BUZZER_DIV_SEL,
    input wire logic BUZZER_OUT_ENABLE,
    input wire logic OUTPUT_INVERSION_ENABLE,
    // Compare value writes
    input wire logic CMP_WR_HI,
    input wire logic CMP_WR_LO,
    input wire logic CMP_WR_WORD,
    input wire logic [15:0] CMP_WDATA,
    // Interrupt
    input wire logic COMPARE_IRQ_MASK,
    input wire logic COMPARE_IRQ_FLAG_CLR,
    output logic COMPARE_IRQ_FLAG,
    output logic COMPARE_IRQ_REQUEST,
    // Capture and readout
    input wire logic CAPTURE_TRIG,
    output logic [15:0] CAPTURE_VALUE,
    output logic CAPTURE_OK,
    input wire logic READ_REQ,
    output logic [15:0] READ_DATA,
    output logic READ_VALID,
    // Timer output
    output logic TIMER_OUT,
    // Shared buzzer pin
    input wire logic BUZZER_PIN_DIRECTION,
    input wire logic BUZZER_PIN_LATCH,
    input wire logic BYTE_TIMER_OUT_ENABLE,
    input wire logic BYTE_TIMER_OUT,
    output logic BUZZER_PIN_OUT,
    output logic BUZZER_PIN_OE
);
    logic sub_meta;
    logic sub_sync;
    logic sub_prev;
    logic [6:0] pre;
    logic [15:0] counter;
    logic [15:0] compare_value;
    logic [15:0] next_cmp;
    logic irq_level;
    logic inv_prev;
    logic sub_src;
    logic [6:0] pre_mask;
    logic sub_rise;
    logic sub_fall;
    logic count_tick;
    logic mid_tick;
    logic cmp_wr;
    logic match_evt;
    logic inv_active;
    logic cap_ok;
    logic read_ok;

    buzzer_src_if bz ();

    // True when the masked prescaler bits equal the pattern
    function automatic logic pre_hit(input logic [6:0] p, input logic [6:0] m,
                                     input logic [6:0] pat);
        return (p & m) == pat;
    endfunction : pre_hit

    // Subsystem clock pin synchroniser and edge history
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_prev <= 1'b0;
        end else begin
            sub_meta <= SUB_CLK;
            sub_sync <= sub_meta;
            sub_prev <= sub_sync;
        end
    end

    // Count-clock selection and tick generation
    assign sub_src = COUNT_CLK_SEL == buzzer_timer_pkg::CLK_SEL_SUB;
    assign pre_mask = (COUNT_CLK_SEL == buzzer_timer_pkg::CLK_SEL_DIV4) ?
                      buzzer_timer_pkg::PRE_MASK_DIV4 :
                      (COUNT_CLK_SEL == buzzer_timer_pkg::CLK_SEL_DIV64) ?
                      buzzer_timer_pkg::PRE_MASK_DIV64 :
                      buzzer_timer_pkg::PRE_MASK_DIV128;
    assign sub_rise = sub_sync & ~sub_prev;
    assign sub_fall = ~sub_sync & sub_prev;
    // Without the buzzer the subclock is gated by the main clock
    assign count_tick = sub_src ? (sub_rise & (MAIN_CLK_RUN | BUZZER_OUT_ENABLE)) :
                        (MAIN_CLK_RUN & pre_hit(pre, pre_mask, pre_mask));
    assign mid_tick = sub_src ? (sub_fall & (MAIN_CLK_RUN | BUZZER_OUT_ENABLE)) :
                      (MAIN_CLK_RUN & pre_hit(pre, pre_mask, pre_mask >> 1));

    // Compare rewrite by byte or by word
    assign cmp_wr = CMP_WR_HI | CMP_WR_LO | CMP_WR_WORD;
    assign next_cmp = CMP_WR_WORD ? CMP_WDATA :
                      {CMP_WR_HI ? CMP_WDATA[15:8] : compare_value[15:8],
                       CMP_WR_LO ? CMP_WDATA[7:0] : compare_value[7:0]};
    // A match on a tick, or a rewrite landing on the current count
    assign match_evt = (count_tick & (counter == compare_value))
                       | (cmp_wr & (next_cmp == counter));
    assign inv_active = irq_level & OUTPUT_INVERSION_ENABLE;

    // Capture and read permission by clock combination
    assign cap_ok = MAIN_CLK_RUN & ~(sub_src & BUZZER_OUT_ENABLE);
    assign read_ok = sub_src ? (MAIN_CLK_RUN & ~BUZZER_OUT_ENABLE) :
                     (MAIN_CLK_RUN & ~CPU_ON_SUB & CPU_HIGH_SPEED);

    // Buzzer source is the very same count-clock tick
    assign bz.src_tick = count_tick;
    assign bz.div_sel = BUZZER_DIV_SEL;

    buzzer_divider divider_inst (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .bz(bz.divider)
    );

    // Prescaler and free-running counter; a match never clears it
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pre <= buzzer_timer_pkg::PRE_RESET;
            counter <= buzzer_timer_pkg::COUNTER_RESET;
        end else begin
            pre <= MAIN_CLK_RUN ? pre + 7'h01 : pre;
            counter <= count_tick ? counter + 16'h0001 : counter;
        end
    end

    // Compare register; a rewrite onto the current count matches at once
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            compare_value <= buzzer_timer_pkg::COMPARE_RESET;
        end else begin
            compare_value <= next_cmp;
        end
    end

    // Request level high from match to half a count period later
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            irq_level <= 1'b0;
        end else begin
            irq_level <= match_evt | (irq_level & ~mid_tick);
        end
    end

    // Sticky flag, set wins over clear; masked request output
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            COMPARE_IRQ_FLAG <= 1'b0;
            COMPARE_IRQ_REQUEST <= 1'b0;
        end else begin
            COMPARE_IRQ_FLAG <= match_evt | (COMPARE_IRQ_FLAG & ~COMPARE_IRQ_FLAG_CLR);
            COMPARE_IRQ_REQUEST <= match_evt & ~COMPARE_IRQ_MASK;
        end
    end

    // Timer output toggles as inversion meets a high request level
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            inv_prev <= 1'b0;
            TIMER_OUT <= 1'b0;
        end else begin
            inv_prev <= inv_active;
            TIMER_OUT <= TIMER_OUT ^ (inv_active & ~inv_prev);
        end
    end

    // Capture and readout registers
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CAPTURE_VALUE <= buzzer_timer_pkg::CAPTURE_RESET;
            CAPTURE_OK <= 1'b0;
            READ_DATA <= buzzer_timer_pkg::COUNTER_RESET;
            READ_VALID <= 1'b0;
        end else begin
            CAPTURE_VALUE <= (CAPTURE_TRIG & cap_ok) ? counter : CAPTURE_VALUE;
            CAPTURE_OK <= cap_ok;
            READ_DATA <= READ_REQ ? counter : READ_DATA;
            READ_VALID <= READ_REQ & read_ok;
        end
    end

    // Shared pin: latch high or another driver overrides the wave
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            BUZZER_PIN_OUT <= 1'b0;
            BUZZER_PIN_OE <= 1'b0;
        end else begin
            BUZZER_PIN_OUT <= BUZZER_PIN_LATCH | (BUZZER_OUT_ENABLE & bz.wave)
                              | (BYTE_TIMER_OUT_ENABLE & BYTE_TIMER_OUT);
            BUZZER_PIN_OE <= ~BUZZER_PIN_DIRECTION;
        end
    end

    count_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        count_tick |=> counter == $past(counter) + 16'h0001)
        else $error("Counter did not step on a count tick");
    flag_set_wins_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (match_evt && COMPARE_IRQ_FLAG_CLR) |=> COMPARE_IRQ_FLAG)
        else $error("Flag lost when set and clear met");
    irq_window_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (match_evt ##1 !mid_tick && !match_evt) |-> ##1 irq_level)
        else $error("Request level fell before half period");
    irq_end_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (mid_tick && !match_evt) |=> !irq_level)
        else $error("Request level held past half period");
    out_toggle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (inv_active && !inv_prev) |=> TIMER_OUT != $past(TIMER_OUT))
        else $error("Timer output missed an inversion");
    sync_stop_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!MAIN_CLK_RUN && !BUZZER_OUT_ENABLE) |-> !count_tick)
        else $error("Counting with main clock stopped and buzzer off");
    sub_excl_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (sub_src && BUZZER_OUT_ENABLE && READ_REQ) |=> !READ_VALID && !CAPTURE_OK)
        else $error("Read or capture allowed with unsynchronised subclock");
    read_speed_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (READ_REQ && !sub_src && !CPU_HIGH_SPEED) |=> !READ_VALID)
        else $error("Read marked valid at low CPU speed");
    pin_quiet_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        (!BUZZER_OUT_ENABLE && !BUZZER_PIN_LATCH && !BYTE_TIMER_OUT_ENABLE) |=> !BUZZER_PIN_OUT)
        else $error("Buzzer pin active while disabled");
endmodule : buzzer_timer

// >>> buzzer_timer_test.sv
// Purpose: Self-checking bench for the free-running timer with buzzer output.
// Assumes: SYS_CLK is the main clock at 200 MHz; the bench drives every control port.
// Notes: Inputs change 1 ns after the rising edge; outputs are sampled at that moment.
module buzzer_timer_test;
    timeunit 1ns;
    timeprecision 100ps;
    // Stimulus
    logic SYS_CLK = 1'b0, RST = 1'b1, SUB_CLK = 1'b0, MAIN_CLK_RUN = 1'b1, CPU_ON_SUB = 1'b0;
    logic CPU_HIGH_SPEED = 1'b1, BUZZER_OUT_ENABLE = 1'b0, OUTPUT_INVERSION_ENABLE = 1'b0;
    logic [1:0] COUNT_CLK_SEL = 2'h0;
    logic [2:0] BUZZER_DIV_SEL = 3'h0;
    logic CMP_WR_HI = 1'b0, CMP_WR_LO = 1'b0, CMP_WR_WORD = 1'b0, COMPARE_IRQ_MASK = 1'b0;
    logic [15:0] CMP_WDATA = 16'h0000;
    logic COMPARE_IRQ_FLAG_CLR = 1'b0, CAPTURE_TRIG = 1'b0, READ_REQ = 1'b0;
    logic BUZZER_PIN_DIRECTION = 1'b0, BUZZER_PIN_LATCH = 1'b0;
    logic BYTE_TIMER_OUT_ENABLE = 1'b0, BYTE_TIMER_OUT = 1'b0;
    // Observed outputs
    logic COMPARE_IRQ_FLAG, COMPARE_IRQ_REQUEST, CAPTURE_OK, READ_VALID, TIMER_OUT;
    logic BUZZER_PIN_OUT, BUZZER_PIN_OE;
    logic [15:0] CAPTURE_VALUE, READ_DATA;
    int failures = 0;
    int checked = 0;

    buzzer_timer u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .SUB_CLK(SUB_CLK),
        .MAIN_CLK_RUN(MAIN_CLK_RUN), .CPU_ON_SUB(CPU_ON_SUB), .CPU_HIGH_SPEED(CPU_HIGH_SPEED),
        .COUNT_CLK_SEL(COUNT_CLK_SEL), .BUZZER_DIV_SEL(BUZZER_DIV_SEL),
        .BUZZER_OUT_ENABLE(BUZZER_OUT_ENABLE), .OUTPUT_INVERSION_ENABLE(OUTPUT_INVERSION_ENABLE),
        .CMP_WR_HI(CMP_WR_HI), .CMP_WR_LO(CMP_WR_LO), .CMP_WR_WORD(CMP_WR_WORD),
        .CMP_WDATA(CMP_WDATA), .COMPARE_IRQ_MASK(COMPARE_IRQ_MASK),
        .COMPARE_IRQ_FLAG_CLR(COMPARE_IRQ_FLAG_CLR), .COMPARE_IRQ_FLAG(COMPARE_IRQ_FLAG),
        .COMPARE_IRQ_REQUEST(COMPARE_IRQ_REQUEST), .CAPTURE_TRIG(CAPTURE_TRIG),
        .CAPTURE_VALUE(CAPTURE_VALUE), .CAPTURE_OK(CAPTURE_OK), .READ_REQ(READ_REQ),
        .READ_DATA(READ_DATA), .READ_VALID(READ_VALID), .TIMER_OUT(TIMER_OUT),
        .BUZZER_PIN_DIRECTION(BUZZER_PIN_DIRECTION), .BUZZER_PIN_LATCH(BUZZER_PIN_LATCH),
        .BYTE_TIMER_OUT_ENABLE(BYTE_TIMER_OUT_ENABLE), .BYTE_TIMER_OUT(BYTE_TIMER_OUT),
        .BUZZER_PIN_OUT(BUZZER_PIN_OUT), .BUZZER_PIN_OE(BUZZER_PIN_OE));

    // Main clock, 5 ns period
    always #2.5 SYS_CLK = ~SYS_CLK;

    // Advance n edges, then settle past the edge
    task automatic step(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : step

    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    // One-cycle read strobe; returns sampled count and validity, then lets an edge pass
    task automatic read_count(output logic [15:0] v, output logic ok);
        READ_REQ = 1'b1;
        step(1);
        READ_REQ = 1'b0;
        v = READ_DATA;
        ok = READ_VALID;
        step(1);
    endtask : read_count

    // Wait, bounded, for the buzzer pin to reach a level
    task automatic wait_pin(input logic v, output int n);
        for (n = 0; BUZZER_PIN_OUT !== v && n < 40000; n++) step(1);
        check(16'(n < 40000), 16'h0001);
    endtask : wait_pin

    // Masked word rewrite ahead of the count, wait, clear, apply the given mask and inversion, await the match
    task automatic compare_match(input logic mask, input logic inv, output logic req_seen);
        logic [15:0] now, n;
        logic ok;
        int i;
        COMPARE_IRQ_MASK = 1'b1;
        OUTPUT_INVERSION_ENABLE = 1'b0;
        read_count(now, ok);
        n = now + 16'h0006;
        CMP_WDATA = n;
        CMP_WR_WORD = 1'b1;
        step(1);
        CMP_WR_WORD = 1'b0;
        step(5);
        COMPARE_IRQ_FLAG_CLR = 1'b1;
        step(1);
        COMPARE_IRQ_FLAG_CLR = 1'b0;
        COMPARE_IRQ_MASK = mask;
        OUTPUT_INVERSION_ENABLE = inv;
        req_seen = 1'b0;
        for (i = 0; COMPARE_IRQ_FLAG !== 1'b1 && i < 100; i++) begin
            req_seen = req_seen | (COMPARE_IRQ_REQUEST === 1'b1);
            step(1);
        end
        req_seen = req_seen | (COMPARE_IRQ_REQUEST === 1'b1);
        check(16'(i < 100), 16'h0001);
        step(6);
        read_count(now, ok);
        check(16'(now > n), 16'h0001);
    endtask : compare_match

    // Interrupt path: unmasked request, masked request, sticky flag and clear
    task automatic test_compare;
        logic seen;
        logic prev;
        compare_match(1'b0, 1'b0, seen);
        check(16'(seen), 16'h0001);
        check(16'(COMPARE_IRQ_FLAG), 16'h0001);
        compare_match(1'b1, 1'b0, seen);
        check(16'(seen), 16'h0000);
        COMPARE_IRQ_FLAG_CLR = 1'b1;
        step(1);
        COMPARE_IRQ_FLAG_CLR = 1'b0;
        check(16'(COMPARE_IRQ_FLAG), 16'h0000);
        prev = TIMER_OUT;
        compare_match(1'b0, 1'b1, seen);
        check(16'(TIMER_OUT != prev), 16'h0001);
        OUTPUT_INVERSION_ENABLE = 1'b0;
    endtask : test_compare

    // Byte rewrite under mask, then an unmasked rewrite onto a frozen count
    task automatic test_rewrite;
        logic [15:0] now, t;
        logic ok;
        logic seen;
        int i;
        COMPARE_IRQ_MASK = 1'b1;
        OUTPUT_INVERSION_ENABLE = 1'b0;
        read_count(now, ok);
        t = now + 16'h0008;
        CMP_WDATA = t;
        CMP_WR_HI = 1'b1;
        step(1);
        CMP_WR_HI = 1'b0;
        CMP_WR_LO = 1'b1;
        step(1);
        CMP_WR_LO = 1'b0;
        COMPARE_IRQ_FLAG_CLR = 1'b1;
        step(1);
        COMPARE_IRQ_FLAG_CLR = 1'b0;
        step(3);
        COMPARE_IRQ_MASK = 1'b0;
        for (i = 0; COMPARE_IRQ_FLAG !== 1'b1 && i < 100; i++) step(1);
        seen = (COMPARE_IRQ_REQUEST === 1'b1);
        check(16'(seen), 16'h0001);
        read_count(now, ok);
        check(now, t + 16'h0001);
        // Freeze the count, then rewrite it unmasked onto the live value
        MAIN_CLK_RUN = 1'b0;
        read_count(now, ok);
        CMP_WDATA = now;
        CMP_WR_WORD = 1'b1;
        step(1);
        CMP_WR_WORD = 1'b0;
        check(16'(COMPARE_IRQ_REQUEST), 16'h0001);
        MAIN_CLK_RUN = 1'b1;
        COMPARE_IRQ_FLAG_CLR = 1'b1;
        step(1);
        COMPARE_IRQ_FLAG_CLR = 1'b0;
    endtask : test_rewrite

    // Buzzer period from the /4 count clock: ratio * 4 cycles, half high
    task automatic test_buzzer;
        int ratios[6] = '{16, 32, 256, 512, 1024, 2048};
        int hi, lo;
        BUZZER_OUT_ENABLE = 1'b1;
        for (int c = 0; c < 6; c++) begin
            BUZZER_DIV_SEL = 3'(c);
            repeat (2) begin
                wait_pin(1'b0, lo);
                wait_pin(1'b1, lo);
            end
            wait_pin(1'b0, hi);
            wait_pin(1'b1, lo);
            check(16'(hi), 16'(ratios[c] * 2));
            check(16'(lo), 16'(ratios[c] * 2));
        end
        BUZZER_OUT_ENABLE = 1'b0;
        repeat (4) begin
            step(20);
            check(16'(BUZZER_PIN_OUT), 16'h0000);
        end
        BUZZER_PIN_LATCH = 1'b1;
        BUZZER_PIN_DIRECTION = 1'b1;
        step(2);
        check(16'(BUZZER_PIN_OUT), 16'h0001);
        check(16'(BUZZER_PIN_OE), 16'h0000);
        BUZZER_PIN_LATCH = 1'b0;
        BUZZER_PIN_DIRECTION = 1'b0;
        BYTE_TIMER_OUT_ENABLE = 1'b1;
        BYTE_TIMER_OUT = 1'b1;
        step(2);
        check(16'(BUZZER_PIN_OUT), 16'h0001);
        check(16'(BUZZER_PIN_OE), 16'h0001);
        BYTE_TIMER_OUT_ENABLE = 1'b0;
    endtask : test_buzzer

    // Subclock edges, each held for several main cycles
    task automatic sub_edges(input int n);
        repeat (n) begin
            SUB_CLK = 1'b1;
            step(4);
            SUB_CLK = 1'b0;
            step(4);
        end
    endtask : sub_edges

    // Read validity, capture gating and subclock counting
    task automatic test_access;
        logic [15:0] a, b;
        logic ok;
        CAPTURE_TRIG = 1'b1;
        READ_REQ = 1'b1;
        step(1);
        CAPTURE_TRIG = 1'b0;
        READ_REQ = 1'b0;
        check(16'(READ_VALID), 16'h0001);
        check(CAPTURE_VALUE, READ_DATA);
        step(1);
        CPU_HIGH_SPEED = 1'b0;
        read_count(a, ok);
        check(16'(ok), 16'h0000);
        CPU_HIGH_SPEED = 1'b1;
        CPU_ON_SUB = 1'b1;
        read_count(a, ok);
        check(16'(ok), 16'h0000);
        CPU_ON_SUB = 1'b0;
        MAIN_CLK_RUN = 1'b0;
        COUNT_CLK_SEL = 2'h3;
        step(2);
        check(16'(CAPTURE_OK), 16'h0000);
        read_count(a, ok);
        sub_edges(3);
        read_count(b, ok);
        check(b, a);
        MAIN_CLK_RUN = 1'b1;
        step(2);
        read_count(a, ok);
        sub_edges(3);
        step(2);
        read_count(b, ok);
        check(b, a + 16'h0003);
        check(16'(ok), 16'h0001);
        BUZZER_OUT_ENABLE = 1'b1;
        step(2);
        read_count(a, ok);
        check(16'(ok), 16'h0000);
        check(16'(CAPTURE_OK), 16'h0000);
        BUZZER_OUT_ENABLE = 1'b0;
        COUNT_CLK_SEL = 2'h0;
        step(2);
    endtask : test_access

    // Verdict and end of run
    task automatic summarize;
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        step(2);
        RST = 1'b0;
        check(16'(COMPARE_IRQ_FLAG), 16'h0000);
        check(16'(TIMER_OUT), 16'h0000);
        check(CAPTURE_VALUE, 16'h0000);
        test_compare();
        test_rewrite();
        test_access();
        test_buzzer();
        summarize();
    end

    // Watchdog, well beyond the expected run of at most about 47000 cycles
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule : buzzer_timer_test
